// ===== logic/trcs_cnt.sv
// loadable down counter that flags the last cycle of a timed phase
`timescale 1ns/1ps
`default_nettype none
module trcs_cnt #(
    parameter int W = 5
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    // state
    output logic      [W-1:0] count,
    output logic              last
);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;

    // load wins, otherwise count down to zero and hold
    always_comb begin
        count_next = count_reg;
        if (load) begin
            count_next = load_val;
        end else if (count_reg != '0) begin
            count_next = count_reg - W'(1);
        end
    end

    // register the count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;
    assign last  = (count_reg == W'(1)); // final cycle of the phase

endmodule : trcs_cnt
`default_nettype wire

// ===== logic/trcs_ctrl.sv
// control front end of the transceiver dynamic reconfiguration controller
//
// What this block does
// - the channel index input only matters when more than one channel is managed.
// - the channel index is 1, 2, 3 or 4 bits wide for 2, 3-4, 5-8 or 9-16 channels.
// - direction 00 reconfigures both halves, 01 only the receiver, 10 only the transmitter.
// - a transmitter-only request never touches the receiver half, even on a duplex channel.
// - busy stays low for the first clock cycle after power-up.
// - in the second cycle busy rises and offset cancellation starts by itself.
// - busy falls only when offset cancellation or a reconfiguration has completed.
// - offset cancellation lasts exactly 16 clock cycles in this model.
// - analog, channel and PLL reconfiguration are offered per channel, others left running.
// - offset cancellation runs only on receiver or duplex channels; analog works on transmitter, receiver and duplex channels.
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module trcs_ctrl (
    // clock and reset
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    // ahb-lite slave
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic      [31:0]                   hrdata,
    // fabric request port
    input  wire logic                          reconfig_req,
    input  wire logic [trcs_pkg::CH_IDX_W-1:0] chan_addr,
    input  wire logic [1:0]                    dir_sel,
    input  wire logic [1:0]                    kind_sel,
    input  wire logic                          blk_powerdown,
    output logic                               busy,
    // per channel strobes toward the transceiver channels
    output logic      [trcs_pkg::CH_COUNT-1:0] tx_sel,
    output logic      [trcs_pkg::CH_COUNT-1:0] rx_sel,
    output logic      [trcs_pkg::CH_COUNT-1:0] cal_en,
    output logic      [1:0]                    op_kind
);

    localparam int N = trcs_pkg::CH_COUNT;

    // sequencer states
    typedef enum logic [1:0] {
        ST_PWRUP  = 2'b00,
        ST_CAL    = 2'b01,
        ST_READY  = 2'b10,
        ST_RECONF = 2'b11
    } trcs_state_t;

    trcs_state_t           state_reg;
    trcs_state_t           state_next;
    trcs_pkg::trcs_req_t   req_reg;
    trcs_pkg::trcs_req_t   req_next;
    logic                  busy_reg;
    logic                  busy_next;
    logic [N-1:0]          tx_sel_reg;
    logic [N-1:0]          tx_sel_next;
    logic [N-1:0]          rx_sel_reg;
    logic [N-1:0]          rx_sel_next;
    logic [N-1:0]          cal_en_reg;
    logic [N-1:0]          cal_en_next;
    logic [2*N-1:0]        chmode_reg;
    logic [2*N-1:0]        chmode_next;
    logic                  caldone_reg;
    logic                  caldone_next;
    logic                  refused_reg;
    logic                  refused_next;
    logic                  pwrdn_reg;
    logic                  pwrdn_next;
    logic                  wr_pend_reg;
    logic                  wr_pend_next;
    logic [7:0]            wr_addr_reg;
    logic [7:0]            wr_addr_next;
    logic [31:0]           hrdata_reg;
    logic [31:0]           hrdata_next;

    logic                  cnt_load;
    logic [4:0]            cnt_val;
    logic                  cnt_last;
    logic                  req_ok;
    logic                  refuse;
    logic                  recal_go;
    logic                  st_clear_refused;
    logic                  st_clear_pwrdn;
    logic                  chmode_we;
    logic                  addr_phase;
    trcs_pkg::trcs_req_t   req_in;
    trcs_pkg::trcs_mode_t  tgt_mode;

    // one counter times both the cancellation and the reconfiguration phases
    trcs_cnt #(
        .W        (trcs_pkg::CNT_W)
    ) u_phase_cnt (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .load     (cnt_load),
        .load_val (cnt_val),
        .count    (),
        .last     (cnt_last)
    );

    // ---------------------------------------------------------------
    // ahb-lite slave: zero wait states, always okay
    // ---------------------------------------------------------------

    // a transfer is taken when selected, non-idle and the bus is ready
    assign addr_phase = hsel && htrans[1] && hready;

    // writes land in the data phase, reads are prepared in the address phase
    always_comb begin
        wr_pend_next = 1'b0;
        wr_addr_next = wr_addr_reg;
        hrdata_next  = hrdata_reg;
        if (addr_phase) begin
            wr_pend_next = hwrite;
            wr_addr_next = {haddr[7:2], 2'b00};
            if (!hwrite) begin
                unique case ({haddr[7:2], 2'b00})
                    trcs_pkg::ADDR_CTRL: begin
                        hrdata_next = '0; // recal bit is a pulse and reads zero
                    end
                    trcs_pkg::ADDR_STATUS: begin
                        hrdata_next = '0;
                        hrdata_next[trcs_pkg::ST_BUSY_BIT]    = busy_reg;
                        hrdata_next[trcs_pkg::ST_CALDONE_BIT] = caldone_reg;
                        hrdata_next[trcs_pkg::ST_REFUSED_BIT] = refused_reg;
                        hrdata_next[trcs_pkg::ST_PWRDN_BIT]   = pwrdn_reg;
                        hrdata_next[trcs_pkg::ST_CHAN_LSB +: trcs_pkg::CH_IDX_W] = req_reg.chan;
                    end
                    trcs_pkg::ADDR_CHMODE: begin
                        hrdata_next = 32'(chmode_reg);
                    end
                    trcs_pkg::ADDR_ACTIVE: begin
                        hrdata_next = '0;
                        hrdata_next[N-1:0] = tx_sel_reg;
                        hrdata_next[trcs_pkg::ACT_RX_LSB +: N] = rx_sel_reg;
                    end
                    default: begin
                        hrdata_next = '0; // unmapped reads zero
                    end
                endcase
            end
        end
    end

    // register the bus side state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg  <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata_reg  <= hrdata_next;
        end
    end

    // data phase write decode
    assign recal_go   = wr_pend_reg && (wr_addr_reg == trcs_pkg::ADDR_CTRL)
                        && hwdata[trcs_pkg::CTRL_RECAL_BIT];
    assign chmode_we  = wr_pend_reg && (wr_addr_reg == trcs_pkg::ADDR_CHMODE);
    assign st_clear_refused = wr_pend_reg && (wr_addr_reg == trcs_pkg::ADDR_STATUS)
                        && hwdata[trcs_pkg::ST_REFUSED_BIT];
    assign st_clear_pwrdn   = wr_pend_reg && (wr_addr_reg == trcs_pkg::ADDR_STATUS)
                        && hwdata[trcs_pkg::ST_PWRDN_BIT];

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // ---------------------------------------------------------------
    // request decode
    // ---------------------------------------------------------------

    // gather the fabric request; a single channel pins the index to zero
    always_comb begin
        req_in.chan = (N > 1) ? chan_addr : '0;
        req_in.dir  = trcs_pkg::trcs_dir_t'(dir_sel);
        req_in.kind = trcs_pkg::trcs_kind_t'(kind_sel);
    end

    // configuration of the addressed channel
    assign tgt_mode = trcs_pkg::trcs_mode_t'(chmode_reg[2*req_in.chan +: 2]);

    // accept legal codes, in-range index and a half the channel really has
    always_comb begin
        req_ok = 1'b1;
        if (req_in.dir == trcs_pkg::DIR_BAD || req_in.kind == trcs_pkg::KIND_BAD) begin
            req_ok = 1'b0;
        end
        if (32'(req_in.chan) >= N) begin
            req_ok = 1'b0;
        end
        if (tgt_mode == trcs_pkg::MODE_NONE) begin
            req_ok = 1'b0;
        end
        if (req_in.dir == trcs_pkg::DIR_RX && tgt_mode == trcs_pkg::MODE_TX) begin
            req_ok = 1'b0; // no receiver to reconfigure
        end
        if (req_in.dir == trcs_pkg::DIR_TX && tgt_mode == trcs_pkg::MODE_RX) begin
            req_ok = 1'b0; // no transmitter to reconfigure
        end
    end

    // ---------------------------------------------------------------
    // sequencer: power-up cancellation, then reconfiguration requests
    // ---------------------------------------------------------------

    // next state, counter load and the request latch
    always_comb begin
        state_next = state_reg;
        req_next   = req_reg;
        cnt_load   = 1'b0;
        cnt_val    = trcs_pkg::CAL_CYCLES;
        refuse     = 1'b0;
        unique case (state_reg)
            ST_PWRUP: begin
                state_next = ST_CAL;
                cnt_load   = 1'b1;
                cnt_val    = trcs_pkg::CAL_CYCLES;
            end
            ST_CAL: begin
                if (cnt_last) begin
                    state_next = ST_READY;
                end
                if (reconfig_req) begin
                    refuse = 1'b1;
                end
            end
            ST_READY: begin
                if (recal_go) begin
                    state_next = ST_CAL;
                    cnt_load   = 1'b1;
                    cnt_val    = trcs_pkg::CAL_CYCLES;
                    refuse     = reconfig_req;
                end else if (reconfig_req) begin
                    if (req_ok) begin
                        state_next = ST_RECONF;
                        req_next   = req_in;
                        cnt_load   = 1'b1;
                        cnt_val    = trcs_pkg::RECONF_CYCLES;
                    end else begin
                        refuse = 1'b1;
                    end
                end
            end
            ST_RECONF: begin
                if (cnt_last) begin
                    state_next = ST_READY;
                end
                if (reconfig_req) begin
                    refuse = 1'b1;
                end
            end
        endcase
    end

    // outputs follow the next state so they change together with busy
    always_comb begin
        busy_next   = (state_next == ST_CAL) || (state_next == ST_RECONF);
        tx_sel_next = '0;
        rx_sel_next = '0;
        cal_en_next = '0;
        for (int i = 0; i < N; i++) begin
            if (state_next == ST_CAL && chmode_reg[2*i +: 2] != trcs_pkg::MODE_TX
                && chmode_reg[2*i +: 2] != trcs_pkg::MODE_NONE) begin
                cal_en_next[i] = 1'b1;
            end
            if (state_next == ST_RECONF && 32'(req_next.chan) == i) begin
                if (req_next.dir != trcs_pkg::DIR_RX
                    && chmode_reg[2*i +: 2] != trcs_pkg::MODE_RX) begin
                    tx_sel_next[i] = 1'b1;
                end
                if (req_next.dir != trcs_pkg::DIR_TX
                    && chmode_reg[2*i +: 2] != trcs_pkg::MODE_TX) begin
                    rx_sel_next[i] = 1'b1;
                end
            end
        end
    end

    // sticky status: completion, refused requests, power-down during cancellation
    always_comb begin
        caldone_next = caldone_reg;
        if (state_reg == ST_CAL && cnt_last) begin
            caldone_next = 1'b1;
        end else if (state_next == ST_CAL) begin
            caldone_next = 1'b0;
        end
        refused_next = refused_reg;
        if (st_clear_refused) begin
            refused_next = 1'b0;
        end
        if (refuse) begin
            refused_next = 1'b1; // set wins over clear
        end
        pwrdn_next = pwrdn_reg;
        if (st_clear_pwrdn) begin
            pwrdn_next = 1'b0;
        end
        if (state_reg == ST_CAL && blk_powerdown) begin
            pwrdn_next = 1'b1;
        end
    end

    // channel configuration written by software
    always_comb begin
        chmode_next = chmode_reg;
        if (chmode_we) begin
            chmode_next = hwdata[2*N-1:0];
        end
    end

    // register the sequencer group
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg   <= ST_PWRUP;
            req_reg     <= '0;
            busy_reg    <= 1'b0;
            tx_sel_reg  <= '0;
            rx_sel_reg  <= '0;
            cal_en_reg  <= '0;
            caldone_reg <= 1'b0;
            refused_reg <= 1'b0;
            pwrdn_reg   <= 1'b0;
            chmode_reg  <= trcs_pkg::CHMODE_RST;
        end else begin
            state_reg   <= state_next;
            req_reg     <= req_next;
            busy_reg    <= busy_next;
            tx_sel_reg  <= tx_sel_next;
            rx_sel_reg  <= rx_sel_next;
            cal_en_reg  <= cal_en_next;
            caldone_reg <= caldone_next;
            refused_reg <= refused_next;
            pwrdn_reg   <= pwrdn_next;
            chmode_reg  <= chmode_next;
        end
    end

    // registered outputs toward fabric and channels
    assign busy    = busy_reg;
    assign tx_sel  = tx_sel_reg;
    assign rx_sel  = rx_sel_reg;
    assign cal_en  = cal_en_reg;
    assign op_kind = req_reg.kind;

    // hsize is accepted but only whole words are meaningful
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:8], haddr[1:0]};

endmodule : trcs_ctrl
`default_nettype wire

// ===== logic/trcs_pkg.sv
// shared constants, types and register map of the reconfiguration channel select block
`default_nettype none
package trcs_pkg;

    // managed channel count and the index width that follows from it
    localparam int CH_COUNT = 4;

    // index width by channel count: 2 -> 1, 3-4 -> 2, 5-8 -> 3, 9-16 -> 4
    function automatic int idx_width(input int n);
        if (n <= 2) begin
            return 1;
        end else if (n <= 4) begin
            return 2;
        end else if (n <= 8) begin
            return 3;
        end
        return 4;
    endfunction : idx_width

    localparam int CH_IDX_W = idx_width(CH_COUNT);

    // timing counts in reconfiguration clock cycles
    localparam int         CNT_W         = 5;
    localparam logic [4:0] CAL_CYCLES    = 5'h10;
    localparam logic [4:0] RECONF_CYCLES = 5'h08;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CHMODE = 8'h08;
    localparam logic [7:0] ADDR_ACTIVE = 8'h0c;

    // field positions
    localparam int CTRL_RECAL_BIT  = 0;
    localparam int ST_BUSY_BIT     = 0;
    localparam int ST_CALDONE_BIT  = 1;
    localparam int ST_REFUSED_BIT  = 2;
    localparam int ST_PWRDN_BIT    = 3;
    localparam int ST_CHAN_LSB     = 4;
    localparam int ACT_RX_LSB      = 16;

    // reset values: every channel starts as duplex
    localparam logic [2*CH_COUNT-1:0] CHMODE_RST = 8'haa;

    // direction select codes
    typedef enum logic [1:0] {
        DIR_BOTH = 2'b00,
        DIR_RX   = 2'b01,
        DIR_TX   = 2'b10,
        DIR_BAD  = 2'b11
    } trcs_dir_t;

    // reconfiguration kinds
    typedef enum logic [1:0] {
        KIND_ANALOG  = 2'b00,
        KIND_CHANNEL = 2'b01,
        KIND_PLL     = 2'b10,
        KIND_BAD     = 2'b11
    } trcs_kind_t;

    // per channel operating configuration
    typedef enum logic [1:0] {
        MODE_TX     = 2'b00,
        MODE_RX     = 2'b01,
        MODE_DUPLEX = 2'b10,
        MODE_NONE   = 2'b11
    } trcs_mode_t;

    // one reconfiguration request as it travels through the block
    typedef struct packed {
        logic [CH_IDX_W-1:0] chan;
        trcs_dir_t           dir;
        trcs_kind_t          kind;
    } trcs_req_t;

endpackage : trcs_pkg
`default_nettype wire

// ===== test/trcs_ctrl_sva.sv
// checker for busy timing and channel selects of the channel select block
`timescale 1ns/1ps
`default_nettype none
module trcs_ctrl_sva (
    // clock and reset
    input wire logic                          hclk,
    input wire logic                          hresetn,
    // fabric request port
    input wire logic                          reconfig_req,
    input wire logic [trcs_pkg::CH_IDX_W-1:0] chan_addr,
    input wire logic [1:0]                    dir_sel,
    input wire logic [1:0]                    kind_sel,
    input wire logic                          busy,
    // channel strobes
    input wire logic [trcs_pkg::CH_COUNT-1:0] tx_sel,
    input wire logic [trcs_pkg::CH_COUNT-1:0] rx_sel,
    input wire logic [trcs_pkg::CH_COUNT-1:0] cal_en,
    input wire logic [1:0]                    op_kind
);
    logic [4:0] cyc_reg;
    logic [4:0] cyc_next;
    logic       sel_any;
    // edges since reset release, saturating at 31
    always_comb begin
        cyc_next = (cyc_reg == 5'h1f) ? cyc_reg : cyc_reg + 5'h01;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_reg <= 5'h00;
        end else begin
            cyc_reg <= cyc_next;
        end
    end
    // any half of any channel selected
    assign sel_any = |(tx_sel | rx_sel);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_busy_first_low: assert property (cyc_reg == 5'h00 |-> !busy)
        else $error("busy high in first cycle");
    chk_cal_running: assert property (cyc_reg >= 5'h01 && cyc_reg <= 5'h10
        |-> busy && cal_en == 4'hf) else $error("cancellation not running");
    chk_cal_ends: assert property (cyc_reg == 5'h11 && !$past(reconfig_req)
        |-> !busy && cal_en == 4'h0) else $error("cancellation length wrong");
    chk_cal_in_busy: assert property (cal_en != 4'h0 |-> busy)
        else $error("cancellation without busy");
    chk_tx_only: assert property (reconfig_req && !busy && dir_sel == 2'b10
        |=> rx_sel == 4'h0) else $error("receiver touched");
    chk_rx_only: assert property (reconfig_req && !busy && dir_sel == 2'b01
        |=> tx_sel == 4'h0) else $error("transmitter touched");
    chk_sel_hold: assert property ($rose(busy) && sel_any
        |-> (busy && sel_any) [*8] ##1 (!busy && !sel_any)) else $error("select length");
    chk_sel_chan: assert property ($rose(busy) && sel_any
        |-> (tx_sel | rx_sel) == (4'h1 << $past(chan_addr)) && op_kind == $past(kind_sel))
        else $error("wrong channel or kind");
    cover property (cyc_reg == 5'h11 && !busy);
    cover property ($rose(busy) && tx_sel != 4'h0 && rx_sel == 4'h0);
    cover property ($rose(busy) && tx_sel != 4'h0 && rx_sel != 4'h0);
endmodule : trcs_ctrl_sva
`default_nettype wire

// ===== test/trcs_ctrl_tb_top.sv
// testbench for the reconfiguration channel select block
`timescale 1ns/1ps
`default_nettype none
module trcs_ctrl_tb_top;
    logic                hclk;
    logic                hresetn;
    logic                hsel;
    logic                hwrite;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [31:0]         haddr;
    logic [31:0]         hwdata;
    logic [31:0]         hrdata;
    logic [31:0]         rd;
    logic                hreadyout;
    logic                hresp;
    logic                reconfig_req;
    logic [1:0]          chan_addr;
    logic [1:0]          dir_sel;
    logic [1:0]          kind_sel;
    logic                blk_powerdown;
    logic                busy;
    logic [3:0]          tx_sel;
    logic [3:0]          rx_sel;
    logic [3:0]          cal_en;
    logic [3:0]          e;
    logic [1:0]          op_kind;
    logic                go;
    logic                rude;
    logic                pd_req;
    trcs_pkg::trcs_req_t g_req;
    int                  errors;
    int                  cmp_count;
    int                  n;
    // design and fabric partner
    trcs_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .reconfig_req(reconfig_req), .chan_addr(chan_addr), .dir_sel(dir_sel),
        .kind_sel(kind_sel), .blk_powerdown(blk_powerdown), .busy(busy),
        .tx_sel(tx_sel), .rx_sel(rx_sel), .cal_en(cal_en), .op_kind(op_kind));
    trcs_fabric u_fab (.hclk(hclk), .hresetn(hresetn), .go(go), .rude(rude),
        .pd_req(pd_req), .g_req(g_req), .busy(busy), .reconfig_req(reconfig_req),
        .chan_addr(chan_addr), .dir_sel(dir_sel), .kind_sel(kind_sel),
        .blk_powerdown(blk_powerdown));
    // 10 mhz clock
    initial hclk = 1'b0;
    always #50 hclk = ~hclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one ahb-lite single word transfer, read data kept in rd
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : ahb
    // fabric request; a rude one ignores busy
    task automatic freq(input logic [1:0] ch, d, k, input logic r);
        while (busy !== 1'b0 && !r) @(posedge hclk);
        @(posedge hclk);
        go    <= 1'b1;
        rude  <= r;
        g_req <= {ch, d, k};
        @(posedge hclk);
        go    <= 1'b0;
        rude  <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
    endtask : freq
    // waits for cancellation, checks its channels and length
    task automatic cal_len(input logic [3:0] exp_cal);
        n = 0;
        while (busy !== 1'b1) @(posedge hclk);
        #1;
        chk({28'h0, cal_en}, {28'h0, exp_cal});
        while (busy === 1'b1) begin
            n++;
            @(posedge hclk);
        end
        chk(n, 32'h10);
    endtask : cal_len
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    // watchdog
    initial begin
        #400000;
        errors++;
        test_done();
    end
    // test sequence
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, go, rude, pd_req} = '0;
        g_req   = '0;
        hsize   = 3'b010;
        hresetn = 1'b0;
        errors  = 0;
        cmp_count = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        cal_len(4'hf);
        ahb(1'b0, trcs_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h7, 32'h2);
        $display("test power-up done");
        for (int i = 0; i < 3; i++) begin
            e = 4'h1 << (3 - i);
            freq(2'(3 - i), 2'(i), 2'(i), 1'b0);
            chk({31'h0, busy}, 32'h1);
            ahb(1'b0, trcs_pkg::ADDR_ACTIVE, 32'h0);
            chk(rd, {12'h0, (i != 2) ? e : 4'h0, 12'h0, (i != 1) ? e : 4'h0});
            chk({30'h0, op_kind}, 32'(i));
            ahb(1'b0, trcs_pkg::ADDR_STATUS, 32'h0);
            chk(rd & 32'h33, {26'h0, 2'(3 - i), 4'h3});
        end
        $display("test directions done");
        freq(2'h0, 2'b00, 2'b00, 1'b0);
        freq(2'h3, 2'b00, 2'b10, 1'b1);
        chk({28'h0, tx_sel}, 32'h1);
        chk({30'h0, op_kind}, 32'h0);
        freq(2'h1, 2'b11, 2'b00, 1'b0);
        chk({31'h0, busy}, 32'h0);
        ahb(1'b0, trcs_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h4);
        ahb(1'b1, trcs_pkg::ADDR_STATUS, 32'h4);
        ahb(1'b0, trcs_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h0);
        // an illegal kind code is refused and leaves busy low
        freq(2'h1, 2'b00, 2'b11, 1'b0);
        chk({31'h0, busy}, 32'h0);
        ahb(1'b0, trcs_pkg::ADDR_STATUS, 32'h0);
        chk(rd & 32'h4, 32'h4);
        $display("test refusals done");
        ahb(1'b1, trcs_pkg::ADDR_CHMODE, 32'ha8);
        ahb(1'b0, trcs_pkg::ADDR_CHMODE, 32'h0);
        chk(rd, 32'ha8);
        ahb(1'b1, trcs_pkg::ADDR_CTRL, 32'h1);
        cal_len(4'he);
        freq(2'h0, 2'b01, 2'b01, 1'b0);
        chk({27'h0, busy, rx_sel}, 32'h0);
        freq(2'h0, 2'b00, 2'b00, 1'b0);
        chk({24'h0, rx_sel, tx_sel}, 32'h1);
        ahb(1'b1, 8'h10, 32'hffffffff);
        ahb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        $display("test modes done");
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        cal_len(4'hf);
        ahb(1'b0, trcs_pkg::ADDR_CHMODE, 32'h0);
        chk(rd, 32'haa);
        $display("test second reset done");
        test_done();
    end
endmodule : trcs_ctrl_tb_top
bind trcs_ctrl trcs_ctrl_sva u_sva (.hclk(hclk), .hresetn(hresetn),
    .reconfig_req(reconfig_req), .chan_addr(chan_addr), .dir_sel(dir_sel),
    .kind_sel(kind_sel), .busy(busy), .tx_sel(tx_sel), .rx_sel(rx_sel),
    .cal_en(cal_en), .op_kind(op_kind));
`default_nettype wire

// ===== test/trcs_fabric.sv
// fabric user logic model that drives the reconfiguration request port
`timescale 1ns/1ps
`default_nettype none
module trcs_fabric (
    // clock and reset
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    // commands from the bench
    input  wire logic                          go,
    input  wire logic                          rude,
    input  wire logic                          pd_req,
    input  wire trcs_pkg::trcs_req_t           g_req,
    // toward the block
    input  wire logic                          busy,
    output logic                               reconfig_req,
    output logic      [trcs_pkg::CH_IDX_W-1:0] chan_addr,
    output logic      [1:0]                    dir_sel,
    output logic      [1:0]                    kind_sel,
    output logic                               blk_powerdown
);
    // one-cycle request, fields held until the next one
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reconfig_req  <= 1'b0;
            chan_addr     <= '0;
            dir_sel       <= 2'b00;
            kind_sel      <= 2'b00;
            blk_powerdown <= 1'b0;
        end else begin
            reconfig_req <= go && (!busy || rude);
            if (go && (!busy || rude)) begin
                {chan_addr, dir_sel, kind_sel} <= g_req;
            end
            blk_powerdown <= pd_req && !busy;
        end
    end
endmodule : trcs_fabric
`default_nettype wire
